// ---- pkg/sync_action_pkg.sv ----
// constants shared by the synchronous action unit and its event units
package sync_action_pkg;

   // ***********************************************************
   // geometry
   // ***********************************************************
   localparam int NUM_AXES = 4;
   localparam int TRIG_W = 10;
   localparam int ACT_W = 12;

   // ***********************************************************
   // register byte offsets
   // ***********************************************************
   localparam logic [5:0] DATA1_OFS = 6'h00;
   localparam logic [5:0] DATA2_OFS = 6'h04;
   localparam logic [5:0] CMD_OFS = 6'h08;
   localparam logic [5:0] MODE2_OFS = 6'h0C;
   localparam logic [5:0] STAT3_OFS = 6'h10;
   localparam logic [5:0] SBUF_OFS = 6'h20;

   // ***********************************************************
   // command word layout and codes
   // ***********************************************************
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_AXES_LSB = 8;
   localparam logic [7:0] CMD_LP_READ = 8'h10;
   localparam logic [7:0] CMD_EXT_MODE = 8'h60;
   localparam logic [7:0] CMD_SYNC_MODE = 8'h64;
   localparam logic [7:0] CMD_SYNC_ACT = 8'h65;

   // ***********************************************************
   // trigger word fields
   // ***********************************************************
   localparam int TRG_GE_UPPER = 0;
   localparam int TRG_LT_UPPER = 1;
   localparam int TRG_LT_LOWER = 2;
   localparam int TRG_GE_LOWER = 3;
   localparam int TRG_DRV_START = 4;
   localparam int TRG_DRV_END = 5;
   localparam int TRG_IN3_RISE = 6;
   localparam int TRG_IN3_FALL = 7;
   localparam int TRG_LP_READ = 8;
   localparam int TRG_SYNC_CMD = 9;
   localparam int OTHER_AXIS_LSB = 13;

   // ***********************************************************
   // action word fields
   // ***********************************************************
   localparam int ACT_FIXED_DRIVE_PLUS_PLUS = 0;
   localparam int ACT_LPOS_SAVE = 6;
   localparam int ACT_RPOS_SAVE = 7;
   localparam int ACT_SYNC_OUT = 14;
   localparam int ACT_IRQ = 15;

   // ***********************************************************
   // status, extension mode, reset values, timing
   // ***********************************************************
   localparam int STAT3_SYNC_BIT = 9;
   localparam int EXT_DCC_EN = 0;
   localparam int EXT_DCC_LVL = 1;
   localparam int EXT_WIDTH_LSB = 8;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [31:0] BUF_RESET = 32'h0000_0000;
   localparam logic [7:0] DCC_WIDTH_RESET = 8'h01;
   localparam int EVENT_TO_PULSE_CYCLES = 5;

endpackage : sync_action_pkg

// ---- pkg/axis_event_if.sv ----
// signals between the action unit and one axis event unit
interface axis_event_if;
   logic [9:0] trig;
   logic cmp_src;
   logic [31:0] lpos;
   logic [31:0] rpos;
   logic [31:0] cmp_hi;
   logic [31:0] cmp_lo;
   logic busy;
   logic in3;
   logic lp_read;
   logic act_cmd;
   logic fire;

   modport unit (
      input trig, cmp_src, lpos, rpos, cmp_hi, cmp_lo,
      input busy, in3, lp_read, act_cmd,
      output fire
   );
   modport ctrl (
      output trig, cmp_src, lpos, rpos, cmp_hi, cmp_lo,
      output busy, in3, lp_read, act_cmd,
      input fire
   );
endinterface : axis_event_if

// ---- rtl/axis_event_unit.sv ----
// per-axis trigger event detector of the synchronous action unit
module axis_event_unit
   import sync_action_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // link to the action unit
   axis_event_if.unit ev
);

   // ***********************************************************
   // condition levels and their first cycle
   // ***********************************************************
   logic signed [31:0] pos;
   logic [TRIG_W-1:0] cond_d;
   logic [TRIG_W-1:0] cond_q;
   logic [TRIG_W-1:0] prev_q;
   logic [TRIG_W-1:0] pulse;
   logic fire_q;

   assign pos = ev.cmp_src ? ev.rpos : ev.lpos; // RULE4

   always_comb begin
      cond_d = '0;
      cond_d[TRG_GE_UPPER] = pos >= $signed(ev.cmp_hi); // RULE4
      cond_d[TRG_LT_UPPER] = pos < $signed(ev.cmp_hi); // RULE5
      cond_d[TRG_LT_LOWER] = pos < $signed(ev.cmp_lo); // RULE6
      cond_d[TRG_GE_LOWER] = pos >= $signed(ev.cmp_lo); // RULE7
      cond_d[TRG_DRV_START] = ev.busy; // RULE8
      cond_d[TRG_DRV_END] = ~ev.busy; // RULE8
      cond_d[TRG_IN3_RISE] = ev.in3; // RULE8
      cond_d[TRG_IN3_FALL] = ~ev.in3; // RULE8
      cond_d[TRG_LP_READ] = ev.lp_read; // RULE9
      cond_d[TRG_SYNC_CMD] = ev.act_cmd; // RULE10
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cond_q <= '0;
         prev_q <= '0;
      end else begin
         cond_q <= cond_d;
         prev_q <= cond_q;
      end
   end

   // levels fire once on entry; command events are already pulses
   always_comb begin
      pulse = cond_q & ~prev_q; // RULE24
      pulse[TRG_LP_READ] = cond_q[TRG_LP_READ];
      pulse[TRG_SYNC_CMD] = cond_q[TRG_SYNC_CMD];
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fire_q <= 1'b0;
      end else begin
         fire_q <= |(pulse & ev.trig); // RULE1 RULE3 RULE24
      end
   end

   assign ev.fire = fire_q;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_upper_reach: assert property ( // RULE4
      (cond_d[TRG_GE_UPPER] && !cond_q[TRG_GE_UPPER]
       && ev.trig[TRG_GE_UPPER]) ##1 ev.trig[TRG_GE_UPPER] |=> fire_q)
      else $error("upper compare reach did not fire");

   a_below_lower: assert property ( // RULE6
      (cond_d[TRG_LT_LOWER] && !cond_q[TRG_LT_LOWER]
       && ev.trig[TRG_LT_LOWER]) ##1 ev.trig[TRG_LT_LOWER] |=> fire_q)
      else $error("below lower compare did not fire");

   a_cmd_event: assert property ( // RULE10
      (ev.act_cmd && ev.trig[TRG_SYNC_CMD]) ##1 ev.trig[TRG_SYNC_CMD]
      |=> fire_q)
      else $error("activation command did not fire");

   a_level_once: assert property ( // RULE24
      (ev.trig == 10'h001 && cond_q[TRG_GE_UPPER] && prev_q[TRG_GE_UPPER])
      |=> !fire_q)
      else $error("persisting compare fired again");

   a_disabled_quiet: assert property ( // RULE3
      (ev.trig == 10'h000) |=> !fire_q)
      else $error("fired with every trigger disabled");

endmodule : axis_event_unit

// ---- rtl/axis_sync_action_unit.sv ----
// four-axis synchronous action unit with an avalon-mm register slave
//
// Summary of operation
// RULE1 - an enabled trigger of an axis starts its enabled actions at once
// RULE2 - mode command latches trigger word and action word for chosen axes
// RULE3 - trigger and other-axis bits enable with 1, disable with 0
// RULE4 - D0 fires when selected counter reaches upper value
// RULE5 - D1 fires when compared counter falls below upper value
// RULE6 - D2 fires when compared counter falls below lower value
// RULE7 - D3 fires when compared counter reaches lower value
// RULE8 - D4/D5 drive start/end, D6/D7 input 3 rise/fall
// RULE9 - D8 fires when logical position read command is written
// RULE10 - D9 fires on the activation command
// RULE11 - D15..D13 extend own event to other axes in rotated order
// RULE12 - actions D0..D3 start fixed or continuous drives plus or minus
// RULE13 - D4 decelerating stop, D5 instant stop
// RULE14 - D6 saves logical, D7 saves real counter into sync buffer
// RULE15 - D8/D9 load 32-bit data into logical/real counter
// RULE16 - D10 loads pulse count, D11 loads drive speed from data
// RULE17 - D14 pulses drive change output set by extension mode
// RULE18 - D15 asserts interrupt and sets sync flag of status 3
// RULE19 - reading status 3 clears flags and releases interrupt
// RULE20 - reset disables all triggers and actions
// RULE21 - other-axis actions run in the same cycle as own actions
// RULE22 - event to first output pulse takes five clock cycles
// RULE23 - host writes zero to action bits D12 and D13
// RULE24 - enabled triggers are ORed, each sensed as a single pulse
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
module axis_sync_action_unit
   import sync_action_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // register bus
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // axis state from the motion core
   input wire logic [NUM_AXES-1:0][31:0] logical_pos_i,
   input wire logic [NUM_AXES-1:0][31:0] real_pos_i,
   input wire logic [NUM_AXES-1:0][31:0] cmp_upper_i,
   input wire logic [NUM_AXES-1:0][31:0] cmp_lower_i,
   input wire logic [NUM_AXES-1:0] drive_busy_i,
   input wire logic [NUM_AXES-1:0] axis_input3_pin_i,
   // actions toward the motion core
   output logic [NUM_AXES-1:0][ACT_W-1:0] action_pulse_o,
   output logic [31:0] load_value_o,
   // pins
   output logic [NUM_AXES-1:0] drive_change_output_o,
   output logic interrupt_out_n_o,
   output logic interrupt_oe_o
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = nw[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = nw[15:8];
      end
   endfunction

   // axis reached by other-axis bit k-1 of axis b
   function automatic logic [1:0] target_axis(input logic [1:0] b,
                                              input logic [1:0] k);
      target_axis = b + k;
   endfunction

   // ***********************************************************
   // bus slave: one wait cycle, then the access completes
   // ***********************************************************
   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;
   logic wr_acc;
   logic rd_acc;
   logic [3:0] idx;
   logic cmd_wr;
   logic [7:0] cmd_code;
   logic [NUM_AXES-1:0] cmd_axes;

   assign idx = avs_address_i[5:2];
   assign wr_acc = avs_write_i & ~wait_q;
   assign rd_acc = avs_read_i & ~wait_q;
   assign cmd_wr = wr_acc && idx == CMD_OFS[5:2] && avs_byteenable_i[0];
   assign cmd_code = avs_writedata_i[CMD_CODE_LSB +: 8];
   assign cmd_axes = avs_writedata_i[CMD_AXES_LSB +: NUM_AXES];

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read_i & wait_q) begin
         rdata_q <= rd_mux;
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o = rdata_q;

   // ***********************************************************
   // host registers
   // ***********************************************************
   logic [15:0] data1_q;
   logic [15:0] data2_q;
   logic [NUM_AXES-1:0] cmp_src_q;
   logic [NUM_AXES-1:0][TRIG_W-1:0] trig_q;
   logic [NUM_AXES-1:0][2:0] other_q;
   logic [NUM_AXES-1:0][15:0] act_q;
   logic [NUM_AXES-1:0] dcc_en_q;
   logic [NUM_AXES-1:0] dcc_lvl_q;
   logic [NUM_AXES-1:0][7:0] dcc_width_q;
   logic [NUM_AXES-1:0] lp_read_q;
   logic [NUM_AXES-1:0] act_cmd_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data1_q <= WORD_RESET;
         data2_q <= WORD_RESET;
         cmp_src_q <= '0;
      end else if (wr_acc) begin
         if (idx == DATA1_OFS[5:2]) begin
            data1_q <= merge16(data1_q, avs_writedata_i[15:0],
                               avs_byteenable_i[1:0]);
         end
         if (idx == DATA2_OFS[5:2]) begin
            data2_q <= merge16(data2_q, avs_writedata_i[15:0],
                               avs_byteenable_i[1:0]);
         end
         if (idx == MODE2_OFS[5:2] && avs_byteenable_i[0]) begin
            cmp_src_q <= avs_writedata_i[NUM_AXES-1:0]; // RULE4
         end
      end
   end

   // mode and extension commands act on every selected axis
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         trig_q <= '0; // RULE20
         other_q <= '0; // RULE20
         act_q <= '0; // RULE20
         dcc_en_q <= '0;
         dcc_lvl_q <= '0;
         dcc_width_q <= {NUM_AXES{DCC_WIDTH_RESET}};
      end else if (cmd_wr) begin
         for (int a = 0; a < NUM_AXES; a++) begin
            if (cmd_axes[a] && cmd_code == CMD_SYNC_MODE) begin
               trig_q[a] <= data1_q[TRIG_W-1:0]; // RULE2 RULE3
               other_q[a] <= data1_q[OTHER_AXIS_LSB +: 3]; // RULE2 RULE3
               act_q[a] <= data2_q; // RULE2
            end
            if (cmd_axes[a] && cmd_code == CMD_EXT_MODE) begin
               dcc_en_q[a] <= data1_q[EXT_DCC_EN]; // RULE17
               dcc_lvl_q[a] <= data1_q[EXT_DCC_LVL]; // RULE17
               dcc_width_q[a] <= data1_q[EXT_WIDTH_LSB +: 8]; // RULE17
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         lp_read_q <= '0;
         act_cmd_q <= '0;
      end else begin
         lp_read_q <= cmd_wr && cmd_code == CMD_LP_READ ? cmd_axes : '0;
         act_cmd_q <= cmd_wr && cmd_code == CMD_SYNC_ACT ? cmd_axes : '0;
      end
   end

   // ***********************************************************
   // input 3 pins cross in from outside
   // ***********************************************************
   logic [NUM_AXES-1:0] in3_meta_q;
   logic [NUM_AXES-1:0] in3_sync_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         in3_meta_q <= '0;
         in3_sync_q <= '0;
      end else begin
         in3_meta_q <= axis_input3_pin_i;
         in3_sync_q <= in3_meta_q;
      end
   end

   // ***********************************************************
   // event units
   // ***********************************************************
   logic [NUM_AXES-1:0] fire;

   for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
      axis_event_if ev ();
      assign ev.trig = trig_q[g];
      assign ev.cmp_src = cmp_src_q[g];
      assign ev.lpos = logical_pos_i[g];
      assign ev.rpos = real_pos_i[g];
      assign ev.cmp_hi = cmp_upper_i[g];
      assign ev.cmp_lo = cmp_lower_i[g];
      assign ev.busy = drive_busy_i[g];
      assign ev.in3 = in3_sync_q[g];
      assign ev.lp_read = lp_read_q[g];
      assign ev.act_cmd = act_cmd_q[g];
      assign fire[g] = ev.fire;
      axis_event_unit u_event (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .ev(ev.unit)
      );
   end

   // ***********************************************************
   // activation fan-out and fixed pipeline to the actions
   // ***********************************************************
   logic [NUM_AXES-1:0] go_d;
   logic [NUM_AXES-1:0] go_q;
   logic [NUM_AXES-1:0] go2_q;

   always_comb begin
      go_d = fire; // RULE1
      for (int b = 0; b < NUM_AXES; b++) begin
         for (int k = 1; k < NUM_AXES; k++) begin
            if (fire[b] && other_q[b][k-1]) begin
               go_d[target_axis(2'(b), 2'(k))] = 1'b1; // RULE11 RULE21
            end
         end
      end
   end

   // pipeline padded so that compare and drive events see the same delay; input 3 adds two synchronizer cycles and the commands one register cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         go_q <= '0;
         go2_q <= '0;
      end else begin
         go_q <= go_d; // RULE22
         go2_q <= go_q; // RULE22
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         action_pulse_o <= '0;
         load_value_o <= 32'h0000_0000;
      end else begin
         load_value_o <= {data2_q, data1_q}; // RULE15 RULE16
         for (int a = 0; a < NUM_AXES; a++) begin
            // drives, stops and loads leave as one strobe each
            action_pulse_o[a] <= go2_q[a] // RULE12 RULE13 RULE15 RULE16
               ? act_q[a][ACT_W-1:0] : '0;
         end
      end
   end

   // ***********************************************************
   // sync buffers
   // ***********************************************************
   logic [NUM_AXES-1:0][31:0] sbuf_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sbuf_q <= {NUM_AXES{BUF_RESET}};
      end else begin
         for (int a = 0; a < NUM_AXES; a++) begin
            if (go2_q[a] && act_q[a][ACT_LPOS_SAVE]) begin
               sbuf_q[a] <= logical_pos_i[a]; // RULE14
            end else if (go2_q[a] && act_q[a][ACT_RPOS_SAVE]) begin
               sbuf_q[a] <= real_pos_i[a]; // RULE14
            end
         end
      end
   end

   // ***********************************************************
   // sync flags and interrupt
   // ***********************************************************
   logic [NUM_AXES-1:0] flag_q;
   logic [NUM_AXES-1:0] flag_d;

   always_comb begin
      for (int a = 0; a < NUM_AXES; a++) begin
         // a new event beats the read-clear in the same cycle
         flag_d[a] = (flag_q[a] & ~(rd_acc &&
                      idx == 4'(STAT3_OFS[5:2] + a))) // RULE19
                     | (go2_q[a] & act_q[a][ACT_IRQ]); // RULE18
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flag_q <= '0;
         interrupt_out_n_o <= 1'b1;
         interrupt_oe_o <= 1'b0;
      end else begin
         flag_q <= flag_d;
         interrupt_out_n_o <= ~|flag_d; // RULE18 RULE19
         interrupt_oe_o <= |flag_d; // RULE18 RULE19
      end
   end

   // ***********************************************************
   // drive change output pulses
   // ***********************************************************
   logic [NUM_AXES-1:0][7:0] dcc_cnt_q;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dcc_cnt_q <= '0;
         drive_change_output_o <= '1;
      end else begin
         for (int a = 0; a < NUM_AXES; a++) begin
            if (go2_q[a] && act_q[a][ACT_SYNC_OUT] && dcc_en_q[a]) begin
               // a width of zero still gives one cycle
               dcc_cnt_q[a] <= dcc_width_q[a] == 8'h00
                  ? 8'h01 : dcc_width_q[a]; // RULE17
            end else if (dcc_cnt_q[a] != 8'h00) begin
               dcc_cnt_q[a] <= dcc_cnt_q[a] - 8'h01;
            end
            drive_change_output_o[a] <= dcc_cnt_q[a] != 8'h00
               ? dcc_lvl_q[a] : ~dcc_lvl_q[a]; // RULE17
         end
      end
   end

   // ***********************************************************
   // read mux; trigger and action words are write only
   // ***********************************************************
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (idx == DATA1_OFS[5:2]) begin
         rd_mux[15:0] = data1_q;
      end else if (idx == DATA2_OFS[5:2]) begin
         rd_mux[15:0] = data2_q;
      end else if (idx == MODE2_OFS[5:2]) begin
         rd_mux[NUM_AXES-1:0] = cmp_src_q;
      end else if (idx[3:2] == STAT3_OFS[5:4]) begin
         rd_mux[STAT3_SYNC_BIT] = flag_q[idx[1:0]];
      end else if (idx[3:2] == SBUF_OFS[5:4]) begin
         rd_mux = sbuf_q[idx[1:0]];
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_own_fire_start: assert property ( // RULE1
      (fire[0] && act_q[0][ACT_FIXED_DRIVE_PLUS_PLUS]) ##1 act_q[0][ACT_FIXED_DRIVE_PLUS_PLUS]
      ##1 act_q[0][ACT_FIXED_DRIVE_PLUS_PLUS] |=> action_pulse_o[0][ACT_FIXED_DRIVE_PLUS_PLUS])
      else $error("own action not issued three cycles after fire");

   a_other_axis_go: assert property ( // RULE21
      (fire[0] && other_q[0][0]) |=> go_q[1] ##1 go2_q[1])
      else $error("other axis not activated with own axis");

   a_rotate_map: assert property ( // RULE11
      (fire == 4'h2 && other_q[1] == 3'h4) |=> go_q == 4'h3)
      else $error("other-axis selection hit the wrong axis");

   a_mode_latch: assert property ( // RULE2
      (cmd_wr && cmd_code == CMD_SYNC_MODE && cmd_axes[0])
      |=> trig_q[0] == $past(data1_q[TRIG_W-1:0])
          && act_q[0] == $past(data2_q))
      else $error("mode command did not latch data words");

   a_reset_clear: assert property ( // RULE20
      $past(reset_i) |-> trig_q == '0 && act_q == '0 && other_q == '0)
      else $error("trigger or action enabled after reset");

   a_save_logical: assert property ( // RULE14
      (go2_q[0] && act_q[0][ACT_LPOS_SAVE])
      |=> sbuf_q[0] == $past(logical_pos_i[0]))
      else $error("logical position not saved to buffer");

   a_irq_set: assert property ( // RULE18
      (go2_q[0] && act_q[0][ACT_IRQ])
      |=> flag_q[0] && !interrupt_out_n_o && interrupt_oe_o)
      else $error("interrupt action did not raise flag and pin");

   a_read_release: assert property ( // RULE19
      (rd_acc && idx == STAT3_OFS[5:2] && flag_q == 4'h1 && go2_q == '0)
      |=> !interrupt_oe_o && interrupt_out_n_o && flag_q == '0)
      else $error("status read did not release interrupt");

   a_dcc_pulse: assert property ( // RULE17
      (go2_q[1] && act_q[1][ACT_SYNC_OUT] && dcc_en_q[1])
      |=> ##1 drive_change_output_o[1] == dcc_lvl_q[1])
      else $error("drive change pulse not emitted");

   c_cross_axis: cover property (fire[0] && other_q[0] != 3'h0);
   c_irq_read: cover property (rd_acc && flag_q != '0);
   c_two_fire: cover property (fire[1] && fire[2]);

endmodule : axis_sync_action_unit

// ---- sim/host_model.sv ----
// host cpu model acting as avalon-mm master of the register slave
module host_model (
   // clock
   input wire logic clk_i,
   // avalon-mm master side
   output logic [5:0] address_o = 6'h00,
   output logic read_o = 1'b0,
   output logic write_o = 1'b0,
   output logic [31:0] writedata_o = 32'h0000_0000,
   output logic [3:0] byteenable_o = 4'hF,
   input wire logic [31:0] readdata_i,
   input wire logic waitrequest_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // request held until waitrequest is seen low
   task automatic xfer(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      address_o <= a;
      writedata_o <= d;
      write_o <= w;
      read_o <= !w;
      do @(posedge clk_i); while (waitrequest_i !== 1'b0);
      q = readdata_i;
      write_o <= 1'b0;
      read_o <= 1'b0;
   endtask
endmodule // host_model

// ---- sim/tb_top.sv ----
// self-checking bench of the synchronous action unit
module tb_top import sync_action_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [5:0] adr;
   logic rd, wr, wrq, int_n, oe;
   logic [NUM_AXES-1:0] busy = '0, in3 = '0, dcc;
   int waited;
   logic [3:0] be;
   logic [31:0] wd, rdat, q, ld;
   logic [NUM_AXES-1:0][31:0] lpos = '0, rpos = '0, cup = '0, clo = '0;
   logic [NUM_AXES-1:0][ACT_W-1:0] act;
   int fails = 0;
   int checks_done = 0;
   always #10 clk_i = ~clk_i;
   host_model h_u (.clk_i(clk_i), .address_o(adr), .read_o(rd),
      .write_o(wr), .writedata_o(wd), .byteenable_o(be),
      .readdata_i(rdat), .waitrequest_i(wrq));
   axis_sync_action_unit dut_u (.clk_i(clk_i), .reset_i(reset_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
      .logical_pos_i(lpos), .real_pos_i(rpos), .cmp_upper_i(cup),
      .cmp_lower_i(clo), .drive_busy_i(busy), .axis_input3_pin_i(in3),
      .action_pulse_o(act), .load_value_o(ld),
      .drive_change_output_o(dcc), .interrupt_out_n_o(int_n),
      .interrupt_oe_o(oe));
   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic mode(input logic [3:0] ax, input logic [15:0] t, a);
      h_u.xfer(1'b1, DATA1_OFS, {16'h0000, t}, q);
      h_u.xfer(1'b1, DATA2_OFS, {16'h0000, a}, q);
      h_u.xfer(1'b1, CMD_OFS, {20'h00000, ax, CMD_SYNC_MODE}, q);
   endtask
   // bounded wait; the action pulse lasts a single cycle
   task automatic wait_act(input int ax);
      waited = 0;
      while (act[ax] === '0 && waited < 20) begin
         @(posedge clk_i);
         waited++;
      end
   endtask
   task automatic end_of_test;
      $display("fails=%0d checks_done=%0d", fails, checks_done);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic test_cmd;
      cup[0] <= 32'h0000_0064;
      rpos[0] <= 32'h0000_1234;
      mode(4'h1, 16'h2200, 16'h8001);
      mode(4'h2, 16'h0000, 16'h0004);
      h_u.xfer(1'b1, CMD_OFS, {20'h00000, 4'h1, CMD_SYNC_ACT}, q);
      wait_act(0);
      chk({8'h00, act[1], act[0]}, 32'h0000_4001);
      repeat (3) @(posedge clk_i);
      chk({30'h0, oe, int_n}, 32'h0000_0002);
      h_u.xfer(1'b0, STAT3_OFS, 32'h0, q);
      chk(32'(q[9]), 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk(32'(int_n), 32'h0000_0001);
   endtask
   task automatic test_cmp;
      mode(4'h1, 16'h0001, 16'h0040);
      lpos[0] <= 32'h0000_0064;
      wait_act(0);
      chk(waited, EVENT_TO_PULSE_CYCLES + 1);
      chk(32'(act[0]), 32'h0000_0040);
      h_u.xfer(1'b0, SBUF_OFS, 32'h0, q);
      chk(q, 32'h0000_0064);
   endtask
   task automatic test_lpread;
      mode(4'h1, 16'h0100, 16'h0080);
      h_u.xfer(1'b1, CMD_OFS, {20'h00000, 4'h1, CMD_LP_READ}, q);
      wait_act(0);
      chk(32'(act[0]), 32'h0000_0080);
      h_u.xfer(1'b0, SBUF_OFS, 32'h0, q);
      chk(q, 32'h0000_1234);
   endtask
   task automatic test_dcc;
      h_u.xfer(1'b1, DATA1_OFS, 32'h0000_0301, q);
      h_u.xfer(1'b1, CMD_OFS, {20'h00000, 4'h2, CMD_EXT_MODE}, q);
      mode(4'h2, 16'h8200, 16'h4001);
      h_u.xfer(1'b1, CMD_OFS, {20'h00000, 4'h2, CMD_SYNC_ACT}, q);
      wait_act(1);
      chk({8'h00, act[1], act[0]}, 32'h0000_1080);
      chk(ld, 32'h4001_8200);
      @(posedge clk_i);
      chk(32'(dcc), 32'h0000_000D);
      repeat (3) @(posedge clk_i);
      chk(32'(dcc), 32'h0000_000F);
   endtask
   task automatic test_pins;
      mode(4'h1, 16'h0090, 16'h0002);
      in3[0] <= 1'b1;
      repeat (4) @(posedge clk_i);
      in3[0] <= 1'b0;
      wait_act(0);
      chk(32'(act[0]), 32'h0000_0002);
      busy[0] <= 1'b1;
      @(posedge clk_i);
      wait_act(0);
      chk(32'(act[0]), 32'h0000_0002);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      chk({8'h00, act[1], act[0]}, 32'h0);
      test_cmd();
      test_cmp();
      test_lpread();
      test_dcc();
      test_pins();
      end_of_test();
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
endmodule // tb_top
